//--- src/csp_pkg.sv
`default_nettype none
package csp_pkg;
  localparam int CLK_PERIOD_NS        = 20;
  localparam int SLOW_LOOP_NS         = 1000000;
  localparam int SLOW_LOOP_STEPPER_NS = 800000;
  localparam int LOOP_CYCLES          = SLOW_LOOP_NS / CLK_PERIOD_NS;
  localparam int STEPPER_LOOP_CYCLES  = SLOW_LOOP_STEPPER_NS / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH           = 32;
  localparam int PDO_W                = 56;

  localparam logic [15:0] OBJ_LIMIT_ENABLE     = 16'h2086;
  localparam logic [15:0] OBJ_PROFILE_VELOCITY = 16'h6081;
  localparam logic [15:0] OBJ_PROFILE_ACCEL    = 16'h6083;
  localparam logic [15:0] OBJ_FAST_LOOP_SYNC   = 16'h2082;

  localparam logic [15:0] LIMIT_ENABLE_RESET     = 16'h0000;
  localparam logic [15:0] LIMIT_ON               = 16'h0001;
  localparam logic [15:0] FAST_LOOP_SYNC_RESET   = 16'h0000;
  localparam logic [31:0] PROFILE_VELOCITY_RESET = 32'h0000_0000;
  localparam logic [31:0] PROFILE_ACCEL_RESET    = 32'h0000_0000;

  localparam logic [15:0] CW_SHUTDOWN  = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE_OP = 16'h000F;
  localparam logic [7:0]  MODE_NONE             = 8'h00;
  localparam logic [7:0]  MODE_CYCLIC_POSITION  = 8'h08;
  localparam logic [7:0]  MODE_CYCLIC_VELOCITY  = 8'h09;

  localparam int CW_REL_BIT         = 6;
  localparam int SW_READY_BIT       = 0;
  localparam int SW_ON_BIT          = 1;
  localparam int SW_ENABLED_BIT     = 2;
  localparam int SW_DISABLED_BIT    = 6;
  localparam int SW_TARGET_USED_BIT = 12;

  typedef enum logic [1:0] {PWR_DISABLED, PWR_READY, PWR_ON, PWR_ENABLED} power_t;

  // Limits a signed error to a magnitude of at most cap.
  function automatic logic signed [31:0] clampStep(input logic signed [31:0] err,
                                                   input logic [31:0] cap);
    logic signed [32:0] e;
    logic signed [32:0] c;
    logic signed [32:0] n;
    e = {err[31], err};
    c = $signed({1'b0, cap});
    n = -c;
    if (e > c) begin
      return c[31:0];
    end else if (e < n) begin
      return n[31:0];
    end
    return err;
  endfunction
endpackage
`default_nettype wire

//--- src/csp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface csp_link_if;
  logic        pdoValid;
  logic        pdoReady;
  logic [15:0] controlWord;
  logic [7:0]  modeOfOperation;
  logic [31:0] targetPosition;
  logic        objValid;
  logic        objReady;
  logic [15:0] objIndex;
  logic [31:0] objData;
  logic [15:0] statusWord;
  logic [31:0] actualPosition;
  logic [31:0] actualVelocity;

  modport drive_mp (
    input  pdoValid, controlWord, modeOfOperation, targetPosition, objValid, objIndex, objData,
    output pdoReady, objReady, statusWord, actualPosition, actualVelocity
  );
  modport master_mp (
    output pdoValid, controlWord, modeOfOperation, targetPosition, objValid, objIndex, objData,
    input  pdoReady, objReady, statusWord, actualPosition, actualVelocity
  );
endinterface
`default_nettype wire

//--- src/sync_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;

  assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
  assign outValid = (wrPtr_r != rdPtr_r);
  assign outData  = mem[rdPtr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
    end else if (inValid && inReady) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdPtr_r <= '0;
    end else if (outValid && outReady) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- src/csp_drive_end.sv
// Operation
// - Master trajectory; drive closes loops, reports actuals.
// - Position mode speed capped by profile velocity with limiting on, by MAX_SPEED with it off.
// - Profile velocity resets zero; zero blocks motion in position mode.
// - Control bit 6 clear: absolute target.
// - Control bit 6 set: target added to position.
// - Status bit 12 shows target in use.
// - Limiting active only when limit object is one.
// - Limits: velocity in position, acceleration in velocity.
// - Limit on, zero profile: motor stays still.
// - Master enables with control words 06, 07, 0F.
// - Mode value 08 selects cyclic position mode.
// - Each new 32-bit target starts a segment.
// - Master sends process data every slow loop.
// - Sync on fast loop object stays zero.
`timescale 1ns/1ns
`default_nettype none
module csp_drive_end
  import csp_pkg::*;
#(
  parameter int          LOOP_CYCLES = csp_pkg::LOOP_CYCLES,
  parameter int          DEPTH       = FIFO_DEPTH,
  parameter logic [31:0] MAX_SPEED   = 32'h0000_1000,
  parameter logic [31:0] MAX_ACCEL   = 32'h0000_0100
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  csp_link_if.drive_mp     link,
  output logic             loopTick,
  output logic [31:0]      demandPosition,
  output logic             limitActive,
  output logic             syncOnFastLoop
);
  if (LOOP_CYCLES < 2) begin
    $error("LOOP_CYCLES must be at least 2");
  end

  logic [31:0]      tickCnt_r;
  logic             fifoValid;
  logic [PDO_W-1:0] fifoData;
  logic             take;
  logic [15:0]      newCw;
  logic [7:0]       newMode;
  logic [31:0]      newTarget;
  logic [15:0]      limitEnable_r;
  logic [31:0]      profileVelocity_r;
  logic [31:0]      profileAccel_r;
  logic [15:0]      fastLoopSync_r;
  power_t           power_r;
  logic [7:0]       mode_r;
  logic [31:0]      targetPos_r;
  logic [31:0]      targetVel_r;
  logic [31:0]      position_r;
  logic [31:0]      velocity_r;
  logic [15:0]      status_r;
  logic             enabled;
  logic             inPosMode;
  logic             inVelMode;
  logic             targetUsed;
  logic [31:0]      velCap;
  logic [31:0]      accCap;

  // Targets queue here and leave one per loop tick, so a master that bursts is
  // held off by pdoReady instead of overwriting a segment still being run.
  sync_fifo #(
    .WIDTH (PDO_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (link.pdoValid),
    .inReady  (link.pdoReady),
    .inData   ({link.controlWord, link.modeOfOperation, link.targetPosition}),
    .outValid (fifoValid),
    .outReady (loopTick),
    .outData  (fifoData)
  );

  assign link.objReady = 1'b1;
  assign loopTick      = (tickCnt_r == 32'(LOOP_CYCLES - 1));
  assign take          = loopTick && fifoValid;
  assign newCw         = fifoData[55:40];
  assign newMode       = fifoData[39:32];
  assign newTarget     = fifoData[31:0];

  always_ff @(posedge clk) begin
    if (!rst_n || loopTick) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      limitEnable_r     <= LIMIT_ENABLE_RESET;
      profileVelocity_r <= PROFILE_VELOCITY_RESET;
      profileAccel_r    <= PROFILE_ACCEL_RESET;
      fastLoopSync_r    <= FAST_LOOP_SYNC_RESET;
    end else if (link.objValid) begin
      unique case (link.objIndex)
        OBJ_LIMIT_ENABLE:     limitEnable_r <= link.objData[15:0];
        OBJ_PROFILE_VELOCITY: profileVelocity_r <= link.objData;
        OBJ_PROFILE_ACCEL:    profileAccel_r <= link.objData;
        OBJ_FAST_LOOP_SYNC:   fastLoopSync_r <= link.objData[15:0];
        default: begin
        end
      endcase
    end
  end

  // Any word that breaks the enable sequence drops the drive back to disabled.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_r <= PWR_DISABLED;
    end else if (take) begin
      unique case (power_r)
        PWR_DISABLED: power_r <= (newCw == CW_SHUTDOWN) ? PWR_READY : PWR_DISABLED;
        PWR_READY: begin
          if (newCw == CW_SWITCH_ON) begin
            power_r <= PWR_ON;
          end else if (newCw != CW_SHUTDOWN) begin
            power_r <= PWR_DISABLED;
          end
        end
        PWR_ON: begin
          if (newCw == CW_ENABLE_OP) begin
            power_r <= PWR_ENABLED;
          end else if (newCw != CW_SWITCH_ON) begin
            power_r <= PWR_DISABLED;
          end
        end
        PWR_ENABLED: begin
          if (newCw[3:0] != CW_ENABLE_OP[3:0]) begin
            power_r <= PWR_DISABLED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= MODE_NONE;
    end else if (take) begin
      mode_r <= newMode;
    end
  end

  assign enabled     = (power_r == PWR_ENABLED);
  assign inPosMode   = enabled && (mode_r == MODE_CYCLIC_POSITION);
  assign inVelMode   = enabled && (mode_r == MODE_CYCLIC_VELOCITY);
  assign limitActive = (limitEnable_r == LIMIT_ON);
  // A zero profile velocity holds the target off even with limiting off.
  assign targetUsed  = inPosMode && (profileVelocity_r != 32'h0000_0000);
  assign velCap      = limitActive ? profileVelocity_r : MAX_SPEED;
  assign accCap      = limitActive ? profileAccel_r : MAX_ACCEL;

  // A position target is resolved once, on arrival, against the present position.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      targetPos_r <= '0;
    end else if (take && enabled && newMode == MODE_CYCLIC_POSITION) begin
      if (newCw[CW_REL_BIT]) begin
        targetPos_r <= position_r + newTarget;
      end else begin
        targetPos_r <= newTarget;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      targetVel_r <= '0;
    end else if (take && enabled && newMode == MODE_CYCLIC_VELOCITY) begin
      targetVel_r <= newTarget;
    end
  end

  // Each loop tick with the target in use, or in velocity mode, moves one step toward the stored target; a target taken on that tick counts from the next.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      position_r <= '0;
      velocity_r <= '0;
    end else if (loopTick) begin
      if (targetUsed) begin
        velocity_r <= clampStep($signed(targetPos_r - position_r), velCap);
        position_r <= position_r + clampStep($signed(targetPos_r - position_r), velCap);
      end else if (inVelMode) begin
        velocity_r <= velocity_r + clampStep($signed(targetVel_r - velocity_r), accCap);
        position_r <= position_r + velocity_r;
      end else begin
        velocity_r <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r                     <= '0;
      status_r[SW_DISABLED_BIT]    <= (power_r == PWR_DISABLED);
      status_r[SW_READY_BIT]       <= (power_r != PWR_DISABLED);
      status_r[SW_ON_BIT]          <= (power_r == PWR_ON) || enabled;
      status_r[SW_ENABLED_BIT]     <= enabled;
      status_r[SW_TARGET_USED_BIT] <= targetUsed;
    end
  end

  // Actual values go back every cycle so the master can close its trajectory.
  assign link.statusWord     = status_r;
  assign link.actualPosition = position_r;
  assign link.actualVelocity = velocity_r;
  assign demandPosition      = targetPos_r;
  assign syncOnFastLoop      = (fastLoopSync_r != FAST_LOOP_SYNC_RESET);
endmodule
`default_nettype wire

//--- src/csp_master_end.sv
`timescale 1ns/1ns
`default_nettype none
module csp_master_end
  import csp_pkg::*;
#(
  parameter int LOOP_CYCLES = csp_pkg::LOOP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  csp_link_if.master_mp    link,
  input  wire logic        start,
  input  wire logic [15:0] limitEnable,
  input  wire logic [31:0] profileVelocity,
  input  wire logic [31:0] target,
  input  wire logic        relative,
  output logic             running,
  output logic [15:0]      statusSeen,
  output logic [31:0]      positionSeen
);
  if (LOOP_CYCLES < 2) begin
    $error("LOOP_CYCLES must be at least 2");
  end

  typedef enum {M_IDLE, M_CFG_SYNC, M_CFG_LIMIT, M_CFG_VEL, M_PREOP, M_SAFEOP, M_OP,
                M_SHUTDOWN, M_SWITCHON, M_ENABLE, M_RUN} mstate_t;

  mstate_t     state_r;
  logic [31:0] tickCnt_r;
  logic        tick;
  logic        pdoValid_r;
  logic [15:0] cw_r;
  logic [7:0]  mode_r;
  logic [31:0] tgt_r;
  logic        objValid_r;
  logic [15:0] objIndex_r;
  logic [31:0] objData_r;
  logic        sendPdo;
  logic [15:0] sendCw;
  logic [7:0]  sendMode;

  assign tick = (tickCnt_r == 32'(LOOP_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end
  end

  // One word per loop tick; each enable step waits a full period.
  always_comb begin
    sendPdo  = 1'b0;
    sendCw   = CW_SHUTDOWN;
    sendMode = MODE_NONE;
    unique case (state_r)
      M_SHUTDOWN: sendPdo = tick;
      M_SWITCHON: begin
        sendPdo = tick;
        sendCw  = CW_SWITCH_ON;
      end
      M_ENABLE: begin
        sendPdo = tick;
        sendCw  = CW_ENABLE_OP;
      end
      M_RUN: begin
        sendPdo  = tick;
        sendCw   = CW_ENABLE_OP | (16'(relative) << CW_REL_BIT);
        sendMode = MODE_CYCLIC_POSITION;
      end
      default: begin
      end
    endcase
  end

  // A word not taken by the next tick is replaced, since only the latest matters.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdoValid_r <= 1'b0;
      cw_r       <= '0;
      mode_r     <= MODE_NONE;
      tgt_r      <= '0;
    end else if (sendPdo) begin
      pdoValid_r <= 1'b1;
      cw_r       <= sendCw;
      mode_r     <= sendMode;
      tgt_r      <= target;
    end else if (link.pdoReady) begin
      pdoValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= M_IDLE;
    end else begin
      unique case (state_r)
        M_IDLE:      state_r <= start ? M_CFG_SYNC : M_IDLE;
        M_CFG_SYNC:  state_r <= link.objReady ? M_CFG_LIMIT : M_CFG_SYNC;
        M_CFG_LIMIT: state_r <= link.objReady ? M_CFG_VEL : M_CFG_LIMIT;
        M_CFG_VEL:   state_r <= link.objReady ? M_PREOP : M_CFG_VEL;
        M_PREOP:     state_r <= tick ? M_SAFEOP : M_PREOP;
        M_SAFEOP:    state_r <= tick ? M_OP : M_SAFEOP;
        M_OP:        state_r <= tick ? M_SHUTDOWN : M_OP;
        M_SHUTDOWN:  state_r <= tick ? M_SWITCHON : M_SHUTDOWN;
        M_SWITCHON:  state_r <= tick ? M_ENABLE : M_SWITCHON;
        M_ENABLE:    state_r <= tick ? M_RUN : M_ENABLE;
        M_RUN:       state_r <= M_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      objValid_r <= 1'b0;
      objIndex_r <= '0;
      objData_r  <= '0;
    end else begin
      objValid_r <= (state_r == M_CFG_SYNC) || (state_r == M_CFG_LIMIT) || (state_r == M_CFG_VEL);
      unique case (state_r)
        M_CFG_SYNC: begin
          objIndex_r <= OBJ_FAST_LOOP_SYNC;
          objData_r  <= 32'(FAST_LOOP_SYNC_RESET);
        end
        M_CFG_LIMIT: begin
          objIndex_r <= OBJ_LIMIT_ENABLE;
          objData_r  <= 32'(limitEnable);
        end
        M_CFG_VEL: begin
          objIndex_r <= OBJ_PROFILE_VELOCITY;
          objData_r  <= profileVelocity;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusSeen   <= '0;
      positionSeen <= '0;
    end else begin
      statusSeen   <= link.statusWord;
      positionSeen <= link.actualPosition;
    end
  end

  assign link.pdoValid        = pdoValid_r;
  assign link.controlWord     = cw_r;
  assign link.modeOfOperation = mode_r;
  assign link.targetPosition  = tgt_r;
  assign link.objValid        = objValid_r;
  assign link.objIndex        = objIndex_r;
  assign link.objData         = objData_r;
  assign running              = (state_r == M_RUN);
endmodule
`default_nettype wire

//--- tb/csp_link_chk.sv
`timescale 1ns/1ns
`default_nettype none
module csp_link_chk
  import csp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pdoValid,
  input wire logic        pdoReady,
  input wire logic [15:0] controlWord,
  input wire logic [7:0]  modeOfOperation,
  input wire logic        objValid,
  input wire logic        objReady,
  input wire logic [15:0] objIndex,
  input wire logic [31:0] objData,
  input wire logic [15:0] statusWord,
  input wire logic [31:0] actualPosition
);
  logic [31:0] pv_r;
  logic        limOn_r;
  logic [15:0] lastCw_r;
  // The link has no object readback, so the written values are mirrored here.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pv_r    <= PROFILE_VELOCITY_RESET;
      limOn_r <= 1'h0;
    end else if (objValid && objIndex == OBJ_PROFILE_VELOCITY) begin
      pv_r <= objData;
    end else if (objValid && objIndex == OBJ_LIMIT_ENABLE) begin
      limOn_r <= objData[15:0] == LIMIT_ON;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lastCw_r <= 16'h0000;
    end else if (pdoValid && pdoReady) begin
      lastCw_r <= controlWord;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  obj_ready_a: assert property (objReady)
    else $error("object write refused");
  reset_status_a: assert property ($rose(rst_n) |-> ##[1:2] statusWord == 16'h0040)
    else $error("status not disabled after reset");
  status_bits_a: assert property ((statusWord & 16'hEFB8) == 16'h0000)
    else $error("reserved status bit set");
  enabled_state_a: assert property (statusWord[2] |-> statusWord[1:0] == 2'h3 && !statusWord[6])
    else $error("enabled outside switched-on state");
  target_used_a: assert property (statusWord[12] |-> statusWord[2])
    else $error("target used while not enabled");
  zero_vel_still_a: assert property (pv_r == 32'h0 && $past(pv_r) == 32'h0 |-> $stable(actualPosition))
    else $error("moved with zero profile velocity");
  zero_vel_flag_a: assert property (pv_r == 32'h0 && $past(pv_r, 2) == 32'h0 |-> !statusWord[12])
    else $error("target used with zero profile velocity");
  step_cap_a: assert property (limOn_r && $past(limOn_r) |->
    (actualPosition - $past(actualPosition) <= pv_r) || ($past(actualPosition) - actualPosition <= pv_r))
    else $error("position step above profile velocity");
  sync_zero_a: assert property (objValid && objIndex == OBJ_FAST_LOOP_SYNC |-> objData[15:0] == 16'h0)
    else $error("fast loop sync written nonzero");
  run_word_a: assert property (pdoValid && modeOfOperation == MODE_CYCLIC_POSITION |->
    controlWord[3:0] == 4'hF && controlWord[5:4] == 2'h0 && controlWord[15:7] == 9'h0)
    else $error("bad control word in position mode");
  enable_order_a: assert property (pdoValid && pdoReady && controlWord == CW_SWITCH_ON |-> lastCw_r == CW_SHUTDOWN)
    else $error("switch on not preceded by shutdown");
  run_enabled_c: cover property (statusWord == 16'h1007);
  rel_word_c: cover property (pdoValid && controlWord[6]);
  still_target_c: cover property (pv_r == 32'h0 && statusWord[2]);
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import csp_pkg::*;
();
  localparam int LC  = 8;
  localparam int LC2 = 64;
  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  logic        start   = 1'h0;
  logic [15:0] limEn   = 16'h0;
  logic [31:0] profVel = 32'h0;
  logic [31:0] target  = 32'h0;
  logic        rel     = 1'h0;
  logic        mon     = 1'h1;
  logic [31:0] prevD   = 32'h0;
  logic [31:0] pos;
  logic [31:0] r;
  logic        running, loopTick, limAct, syncFast, tick2, limAct2, sync2;
  logic [15:0] statusSeen;
  logic [31:0] posSeen;
  logic [31:0] demand;
  logic [31:0] expQ[$];
  int          n;
  int          err_count = 0;
  int          checked   = 0;
  csp_link_if link ();
  csp_link_if link2 ();
  csp_master_end #(.LOOP_CYCLES(LC)) csp_master_end_inst (.clk(clk), .rst_n(rst_n), .link(link.master_mp),
    .start(start), .limitEnable(limEn), .profileVelocity(profVel), .target(target), .relative(rel),
    .running(running), .statusSeen(statusSeen), .positionSeen(posSeen));
  csp_drive_end #(.LOOP_CYCLES(LC)) csp_drive_end_inst (.clk(clk), .rst_n(rst_n), .link(link.drive_mp),
    .loopTick(loopTick), .demandPosition(demand), .limitActive(limAct), .syncOnFastLoop(syncFast));
  // A second drive end faces the bench, so a broken order and a full queue can be forced.
  csp_drive_end #(.LOOP_CYCLES(LC2)) csp_drive_end_inst2 (.clk(clk), .rst_n(rst_n), .link(link2.drive_mp),
    .loopTick(tick2), .demandPosition(), .limitActive(limAct2), .syncOnFastLoop(sync2));
  csp_link_chk csp_link_chk_inst (.clk(clk), .rst_n(rst_n), .pdoValid(link.pdoValid), .pdoReady(link.pdoReady),
    .controlWord(link.controlWord), .modeOfOperation(link.modeOfOperation), .objValid(link.objValid),
    .objReady(link.objReady), .objIndex(link.objIndex), .objData(link.objData), .statusWord(link.statusWord),
    .actualPosition(link.actualPosition));
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic doReset();
    rst_n  = 1'h0;
    rel    = 1'h0;
    target = 32'h0;
    mon    = 1'h1;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    expQ.delete();
  endtask
  task automatic runUp(input logic [15:0] le, input logic [31:0] pv, input logic [15:0] st);
    doReset();
    limEn   = le;
    profVel = pv;
    start   = 1'h1;
    @(negedge clk);
    start = 1'h0;
    n = 0;
    while (statusSeen !== st && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("status_run", st, statusSeen);
    chk("running", 32'h1, running);
  endtask
  task automatic go(input logic [31:0] t);
    expQ.push_back(t);
    target = t;
    repeat (8 * LC) @(negedge clk);
  endtask
  task automatic obj2(input logic [15:0] idx, input logic [31:0] d);
    link2.objValid = 1'h1;
    link2.objIndex = idx;
    link2.objData  = d;
    @(negedge clk);
    link2.objValid = 1'h0;
    link2.objData  = ~d;
    @(negedge clk);
  endtask
  // The queue is empty here, so ready is high and the word is taken at the next edge.
  task automatic pdo2(input logic [15:0] cw);
    link2.pdoValid    = 1'h1;
    link2.controlWord = cw;
    @(negedge clk);
    link2.pdoValid    = 1'h0;
    link2.controlWord = ~cw;
    repeat (2 * LC2) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (!rst_n) begin
      prevD = 32'h0;
    end else if (demand !== prevD) begin
      prevD = demand;
      if (mon) begin
        chk("demand", expQ.size() > 0 ? expQ.pop_front() : ~demand, demand);
      end
    end
  end
  initial begin
    #(CLK_PERIOD_NS * 20000);
    err_count++;
    results();
  end
  initial begin
    link2.pdoValid        = 1'h0;
    link2.controlWord     = 16'h0;
    link2.modeOfOperation = MODE_NONE;
    link2.targetPosition  = 32'h0;
    link2.objValid        = 1'h0;
    link2.objIndex        = 16'h0;
    link2.objData         = 32'h0;
    void'($urandom(32'h3E52));
    doReset();
    repeat (3) @(negedge clk);
    chk("status_reset", 32'h40, statusSeen);
    chk("flags_reset", 32'h3, {limAct, syncFast, running, link.pdoReady, link.objReady});
    done("reset");
    runUp(16'h1, 32'h100, 16'h1007);
    chk("limit_on", 32'h1, limAct);
    chk("sync_fast", 32'h0, syncFast);
    pos = 32'h0;
    repeat (3) begin
      pos = pos + 32'h40 + ($urandom() & 32'h3FF);
      go(pos);
      chk("pos_abs", pos, posSeen);
    end
    r = 32'h20 + ($urandom() & 32'hFF);
    pos = pos + r;
    expQ.push_back(pos);
    rel    = 1'h1;
    target = r;
    repeat (LC) @(negedge clk);
    rel    = 1'h0;
    target = pos;
    repeat (8 * LC) @(negedge clk);
    chk("pos_rel", pos, posSeen);
    done("run");
    runUp(16'h1, 32'h0, 16'h0007);
    mon    = 1'h0;
    target = 32'h500;
    repeat (6 * LC) @(negedge clk);
    chk("pos_zero_vel", 32'h0, posSeen);
    chk("status_zero_vel", 32'h7, statusSeen);
    done("zero_velocity");
    runUp(16'h2, 32'h4, 16'h1007);
    chk("limit_two", 32'h0, limAct);
    go(32'h800);
    chk("pos_unlimited", 32'h800, posSeen);
    chk("demand_left", 32'h0, expQ.size());
    done("no_limit");
    doReset();
    obj2(16'h1234, 32'h1);
    chk("unknown_obj", 32'h0, limAct2);
    obj2(OBJ_LIMIT_ENABLE, 32'h3);
    chk("limit_three", 32'h0, limAct2);
    obj2(OBJ_LIMIT_ENABLE, 32'h0001_0001);
    chk("limit_one", 32'h1, limAct2);
    obj2(OBJ_FAST_LOOP_SYNC, 32'h1);
    chk("sync_set", 32'h1, sync2);
    pdo2(CW_SHUTDOWN);
    chk("status_ready", 32'h1, link2.statusWord);
    pdo2(CW_ENABLE_OP);
    chk("status_skip", 32'h40, link2.statusWord);
    done("objects_order");
    n = 0;
    while (tick2 !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    link2.pdoValid    = 1'h1;
    link2.controlWord = CW_SHUTDOWN;
    n = 0;
    repeat (40) begin
      n += (link2.pdoReady === 1'h1);
      @(negedge clk);
    end
    chk("fifo_taken", FIFO_DEPTH, n);
    chk("fifo_refuse", 32'h0, link2.pdoReady);
    link2.pdoValid    = 1'h0;
    link2.controlWord = ~CW_SHUTDOWN;
    repeat (LC2) @(negedge clk);
    chk("fifo_pop", 32'h1, link2.pdoReady);
    repeat (33 * LC2) @(negedge clk);
    chk("fifo_drained", 32'h1, link2.pdoReady);
    done("fifo");
    // The queue must be empty by now, or a stale shutdown word would pop before switch on.
    obj2(OBJ_PROFILE_ACCEL, 32'h10);
    link2.modeOfOperation = MODE_CYCLIC_VELOCITY;
    link2.targetPosition  = 32'h100;
    pdo2(CW_SWITCH_ON);
    chk("status_on", 32'h3, link2.statusWord);
    pdo2(CW_ENABLE_OP);
    pdo2(CW_ENABLE_OP);
    chk("status_vel", 32'h7, link2.statusWord);
    n = 0;
    while (tick2 !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    r = link2.actualVelocity;
    repeat (LC2) @(negedge clk);
    chk("vel_step", r + 32'h10, link2.actualVelocity);
    repeat (20 * LC2) @(negedge clk);
    chk("vel_final", 32'h100, link2.actualVelocity);
    done("velocity");
    results();
  end
endmodule
`default_nettype wire
